// ==== hw/ctc_clock_ctrl.sv ====
// Clock task and event controller: tasks, events, status and oscillator enables.
// Assumes oscillators settle as timed here and a strobe register port.
`timescale 1ns/1ps
`default_nettype none

module ctc_clock_ctrl #(
  parameter int CAL_CYCLES = ctc_pkg::CAL_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rd_data,
  output logic             irq,
  output logic             fast_crystal_osc_en,
  output logic             slow_rc_osc_en,
  output logic             slow_crystal_osc_en,
  output logic             slow_clock_on_crystal,
  output logic             cal_ref_request
);

  typedef enum logic [1:0] {HF_OFF, HF_SETTLING, HF_RUNNING} ctc_hf_state_t;
  typedef enum logic [1:0] {SL_OFF, SL_SETTLING, SL_RUNNING} ctc_slow_state_t;
  typedef enum logic [1:0] {CT_STOPPED, CT_STARTING, CT_RUNNING, CT_STOPPING} ctc_ct_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  logic task_hit;
  logic hf_start_task;
  logic hf_stop_task;
  logic slow_start_task;
  logic slow_stop_task;
  logic cal_task;
  logic ct_start_task;
  logic ct_stop_task;

  assign task_hit        = wr_stb && wr_data[0];
  assign hf_start_task   = task_hit && addr == ctc_pkg::OFF_HF_START;
  assign hf_stop_task    = task_hit && addr == ctc_pkg::OFF_HF_STOP;
  assign slow_start_task = task_hit && addr == ctc_pkg::OFF_SLOW_START;
  assign slow_stop_task  = task_hit && addr == ctc_pkg::OFF_SLOW_STOP;
  assign cal_task        = task_hit && addr == ctc_pkg::OFF_CALIBRATE;
  assign ct_start_task   = task_hit && addr == ctc_pkg::OFF_CT_START;
  assign ct_stop_task    = task_hit && addr == ctc_pkg::OFF_CT_STOP;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [17:0] src_sel_reg;
  logic [15:0] hf_settle_reg;
  logic [15:0] slow_settle_reg;
  logic [6:0]  ct_interval_reg;
  logic [17:0] src_snap_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_sel_reg     <= ctc_pkg::SRC_SEL_RST;
      hf_settle_reg   <= ctc_pkg::HF_SETTLE_RST;
      slow_settle_reg <= ctc_pkg::SLOW_SETTLE_RST;
      ct_interval_reg <= ctc_pkg::CT_INTERVAL_RST;
    end else if (wr_stb) begin
      case (addr)
        ctc_pkg::OFF_SRC_SEL: begin
          src_sel_reg <= wr_data[17:0];
        end
        ctc_pkg::OFF_HF_SETTLE: begin
          hf_settle_reg <= wr_data[15:0];
        end
        ctc_pkg::OFF_SLOW_SETTLE: begin
          slow_settle_reg <= wr_data[15:0];
        end
        ctc_pkg::OFF_CT_INTERVAL: begin
          ct_interval_reg <= wr_data[6:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_snap_reg <= '0;
    end else if (slow_start_task) begin
      src_snap_reg <= src_sel_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fast crystal oscillator control.

  ctc_hf_state_t hf_state_reg;
  logic          hf_req_reg;
  logic          hf_load;
  logic          hf_settled;

  assign hf_load = hf_start_task && hf_state_reg == HF_OFF;

  ctc_countdown #(.WIDTH(ctc_pkg::SETTLE_W)) u_hf_settle (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (hf_load),
    .abort   (hf_stop_task),
    .value   (hf_settle_reg),
    .busy    (),
    .done    (hf_settled)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hf_state_reg        <= HF_OFF;
      fast_crystal_osc_en <= 1'b0;
    end else begin
      case (hf_state_reg)
        HF_OFF: begin
          if (hf_start_task) begin
            hf_state_reg        <= HF_SETTLING;
            fast_crystal_osc_en <= 1'b1;
          end
        end
        HF_SETTLING: begin
          if (hf_stop_task) begin
            hf_state_reg        <= HF_OFF;
            fast_crystal_osc_en <= 1'b0;
          end else if (hf_settled) begin
            hf_state_reg <= HF_RUNNING;
          end
        end
        HF_RUNNING: begin
          if (hf_stop_task) begin
            hf_state_reg        <= HF_OFF;
            fast_crystal_osc_en <= 1'b0;
          end
        end
        default: begin
          hf_state_reg <= HF_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hf_req_reg <= 1'b0;
    end else if (hf_start_task) begin
      hf_req_reg <= 1'b1;
    end else if (hf_stop_task) begin
      hf_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slow clock control.

  ctc_slow_state_t slow_state_reg;
  logic            slow_req_reg;
  logic            slow_load;
  logic            slow_settled;
  logic            slow_started;
  logic            pick_crystal;

  assign pick_crystal = src_sel_reg[1:0] == ctc_pkg::SRC_CRYSTAL;
  assign slow_load    = slow_start_task && slow_state_reg == SL_OFF && pick_crystal;

  ctc_countdown #(.WIDTH(ctc_pkg::SETTLE_W)) u_slow_settle (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (slow_load),
    .abort   (slow_stop_task),
    .value   (slow_settle_reg),
    .busy    (),
    .done    (slow_settled)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_state_reg        <= SL_OFF;
      slow_rc_osc_en        <= 1'b0;
      slow_crystal_osc_en   <= 1'b0;
      slow_clock_on_crystal <= 1'b0;
      slow_started          <= 1'b0;
    end else begin
      slow_started <= 1'b0;
      if (slow_stop_task) begin
        slow_state_reg        <= SL_OFF;
        slow_rc_osc_en        <= 1'b0;
        slow_crystal_osc_en   <= 1'b0;
        slow_clock_on_crystal <= 1'b0;
      end else begin
        case (slow_state_reg)
          SL_OFF: begin
            if (slow_start_task && pick_crystal) begin
              slow_state_reg      <= SL_SETTLING;
              slow_rc_osc_en      <= 1'b1;
              slow_crystal_osc_en <= 1'b1;
            end else if (slow_start_task) begin
              slow_state_reg <= SL_RUNNING;
              slow_rc_osc_en <= src_sel_reg[1:0] == ctc_pkg::SRC_RC;
              slow_started   <= 1'b1;
            end
          end
          SL_SETTLING: begin
            if (slow_settled) begin
              slow_state_reg        <= SL_RUNNING;
              slow_rc_osc_en        <= 1'b0;
              slow_clock_on_crystal <= 1'b1;
              slow_started          <= 1'b1;
            end
          end
          SL_RUNNING: begin
          end
          default: begin
            slow_state_reg <= SL_OFF;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_req_reg <= 1'b0;
    end else if (slow_start_task) begin
      slow_req_reg <= 1'b1;
    end else if (slow_stop_task) begin
      slow_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // RC calibration, which needs the fast crystal as its reference.

  logic cal_active_reg;
  logic cal_load;
  logic cal_busy;
  logic cal_done;

  assign cal_load = cal_ref_request && !cal_active_reg && hf_state_reg == HF_RUNNING;

  ctc_countdown #(.WIDTH(16)) u_cal (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (cal_load),
    .abort   (1'b0),
    .value   (16'(CAL_CYCLES - 1)),
    .busy    (cal_busy),
    .done    (cal_done)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_ref_request <= 1'b0;
      cal_active_reg  <= 1'b0;
    end else if (cal_done) begin
      // A calibrate task in the finishing cycle queues the next run.
      cal_ref_request <= cal_task;
      cal_active_reg  <= 1'b0;
    end else if (cal_task && !cal_ref_request) begin
      cal_ref_request <= 1'b1;
    end else if (cal_load) begin
      cal_active_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration timer.

  ctc_ct_state_t ct_state_reg;
  logic          ct_load;
  logic          ct_abort;
  logic          ct_expired;
  logic          ct_busy;

  assign ct_load  = ct_start_task && ct_state_reg == CT_STOPPED;
  assign ct_abort = ct_stop_task && ct_state_reg == CT_RUNNING;

  ctc_countdown #(.WIDTH(ctc_pkg::CT_W)) u_ct (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (ct_load),
    .abort   (ct_abort),
    .value   (ct_interval_reg),
    .busy    (ct_busy),
    .done    (ct_expired)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ct_state_reg <= CT_STOPPED;
    end else begin
      case (ct_state_reg)
        CT_STOPPED, CT_RUNNING: begin
          if (ct_start_task) begin
            ct_state_reg <= CT_STARTING;
          end else if (ct_stop_task) begin
            ct_state_reg <= CT_STOPPING;
          end else if (ct_expired) begin
            ct_state_reg <= CT_STOPPED;
          end
        end
        CT_STARTING: begin
          // A start that met the expiry leaves an idle counter, so fall back to stopped.
          ct_state_reg <= ct_busy ? CT_RUNNING : CT_STOPPED;
        end
        CT_STOPPING: begin
          ct_state_reg <= CT_STOPPED;
        end
        default: begin
          ct_state_reg <= CT_STOPPED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, interrupt status and enables.

  logic [ctc_pkg::NUM_EV-1:0] ev_pulse;
  logic [ctc_pkg::NUM_EV-1:0] event_reg;
  logic [ctc_pkg::NUM_EV-1:0] irq_status_reg;
  logic [ctc_pkg::NUM_EV-1:0] irq_en_reg;
  logic                       status_read;

  assign ev_pulse[ctc_pkg::EV_HF_STARTED] = hf_settled && hf_state_reg == HF_SETTLING;
  assign ev_pulse[ctc_pkg::EV_SLOW_START] = slow_started;
  assign ev_pulse[ctc_pkg::EV_CAL_DONE]   = cal_done;
  assign ev_pulse[ctc_pkg::EV_CT_TIMEOUT] = ct_expired;
  assign ev_pulse[ctc_pkg::EV_CT_STARTED] = ct_state_reg == CT_STARTING;
  assign ev_pulse[ctc_pkg::EV_CT_STOPPED] = ct_state_reg == CT_STOPPING;
  assign status_read = rd_stb && addr == ctc_pkg::OFF_IRQ_STATUS;

  generate
    for (genvar i = 0; i < ctc_pkg::NUM_EV; i++) begin : g_ev
      // A new event wins over a clear in the same cycle.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          event_reg[i]      <= 1'b0;
          irq_status_reg[i] <= 1'b0;
        end else begin
          if (ev_pulse[i]) begin
            event_reg[i] <= 1'b1;
          end else if (wr_stb && addr == ctc_pkg::EV_OFF[i] && !wr_data[0]) begin
            event_reg[i] <= 1'b0;
          end
          if (ev_pulse[i]) begin
            irq_status_reg[i] <= 1'b1;
          end else if (status_read) begin
            irq_status_reg[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_en_reg <= '0;
    end else if (wr_stb && addr == ctc_pkg::OFF_IRQ_EN_SET) begin
      irq_en_reg <= irq_en_reg | wr_data[ctc_pkg::NUM_EV-1:0];
    end else if (wr_stb && addr == ctc_pkg::OFF_IRQ_EN_CLR) begin
      irq_en_reg <= irq_en_reg & ~wr_data[ctc_pkg::NUM_EV-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the read strobe.

  logic [31:0] rd_next;
  logic [1:0]  slow_src_now;

  assign slow_src_now = slow_clock_on_crystal ? ctc_pkg::SRC_CRYSTAL :
                        (src_snap_reg[1:0] == ctc_pkg::SRC_SYNTH ? ctc_pkg::SRC_SYNTH :
                         ctc_pkg::SRC_RC);

  always_comb begin
    rd_next = '0;
    case (addr)
      ctc_pkg::OFF_IRQ_STATUS: begin
        rd_next[ctc_pkg::NUM_EV-1:0] = irq_status_reg;
      end
      ctc_pkg::OFF_IRQ_EN_SET, ctc_pkg::OFF_IRQ_EN_CLR: begin
        rd_next[ctc_pkg::NUM_EV-1:0] = irq_en_reg;
      end
      ctc_pkg::OFF_HF_REQ: begin
        rd_next[0] = hf_req_reg;
      end
      ctc_pkg::OFF_HF_STATE: begin
        rd_next[0]                    = hf_state_reg == HF_RUNNING;
        rd_next[ctc_pkg::RUNNING_BIT] = hf_state_reg == HF_RUNNING;
      end
      ctc_pkg::OFF_SLOW_REQ: begin
        rd_next[0] = slow_req_reg;
      end
      ctc_pkg::OFF_SLOW_STATE: begin
        rd_next[1:0]                  = slow_src_now;
        rd_next[ctc_pkg::RUNNING_BIT] = slow_state_reg != SL_OFF;
      end
      ctc_pkg::OFF_SRC_SNAP: begin
        rd_next[17:0] = src_snap_reg;
      end
      ctc_pkg::OFF_SRC_SEL: begin
        rd_next[17:0] = src_sel_reg;
      end
      ctc_pkg::OFF_HF_SETTLE: begin
        rd_next[15:0] = hf_settle_reg;
      end
      ctc_pkg::OFF_SLOW_SETTLE: begin
        rd_next[15:0] = slow_settle_reg;
      end
      ctc_pkg::OFF_CT_INTERVAL: begin
        rd_next[6:0] = ct_interval_reg;
      end
      default: begin
        for (int i = 0; i < ctc_pkg::NUM_EV; i++) begin
          if (addr == ctc_pkg::EV_OFF[i]) begin
            rd_next[0] = event_reg[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_stb) begin
      rd_data <= rd_next;
    end else begin
      rd_data <= '0;
    end
  end

  // The busy flag of the calibration counter follows cal_active_reg but falls one cycle before it.
  logic cal_unused;
  assign cal_unused = cal_busy;

endmodule : ctc_clock_ctrl

`default_nettype wire

// ==== include/ctc_pkg.sv ====
// Constants shared by the clock task and event controller.
// Assumes a 12-bit byte address on the register port and 32-bit data words.
package ctc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Task registers.
  localparam logic [11:0] OFF_HF_START    = 12'h000;
  localparam logic [11:0] OFF_HF_STOP     = 12'h004;
  localparam logic [11:0] OFF_SLOW_START  = 12'h008;
  localparam logic [11:0] OFF_SLOW_STOP   = 12'h00c;
  localparam logic [11:0] OFF_CALIBRATE   = 12'h010;
  localparam logic [11:0] OFF_CT_START    = 12'h014;
  localparam logic [11:0] OFF_CT_STOP     = 12'h018;

  // Event registers.
  localparam logic [11:0] OFF_EV_HF_STARTED   = 12'h100;
  localparam logic [11:0] OFF_EV_SLOW_STARTED = 12'h104;
  localparam logic [11:0] OFF_EV_CAL_DONE     = 12'h10c;
  localparam logic [11:0] OFF_EV_CT_TIMEOUT   = 12'h110;
  localparam logic [11:0] OFF_EV_CT_STARTED   = 12'h128;
  localparam logic [11:0] OFF_EV_CT_STOPPED   = 12'h12c;

  // Interrupt registers.
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h300;
  localparam logic [11:0] OFF_IRQ_EN_SET  = 12'h304;
  localparam logic [11:0] OFF_IRQ_EN_CLR  = 12'h308;

  // Status and configuration registers.
  localparam logic [11:0] OFF_HF_REQ      = 12'h408;
  localparam logic [11:0] OFF_HF_STATE    = 12'h40c;
  localparam logic [11:0] OFF_SLOW_REQ    = 12'h414;
  localparam logic [11:0] OFF_SLOW_STATE  = 12'h418;
  localparam logic [11:0] OFF_SRC_SNAP    = 12'h41c;
  localparam logic [11:0] OFF_SRC_SEL     = 12'h518;
  localparam logic [11:0] OFF_HF_SETTLE   = 12'h528;
  localparam logic [11:0] OFF_SLOW_SETTLE = 12'h52c;
  localparam logic [11:0] OFF_CT_INTERVAL = 12'h538;

  // Event indices, shared by the status and enable bit layout.
  localparam int NUM_EV        = 6;
  localparam int EV_HF_STARTED = 0;
  localparam int EV_SLOW_START = 1;
  localparam int EV_CAL_DONE   = 2;
  localparam int EV_CT_TIMEOUT = 3;
  localparam int EV_CT_STARTED = 4;
  localparam int EV_CT_STOPPED = 5;

  localparam logic [11:0] EV_OFF [NUM_EV] = '{
    OFF_EV_HF_STARTED, OFF_EV_SLOW_STARTED, OFF_EV_CAL_DONE,
    OFF_EV_CT_TIMEOUT, OFF_EV_CT_STARTED, OFF_EV_CT_STOPPED
  };

  // Source selection values and field positions.
  localparam logic [1:0] SRC_RC      = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_SYNTH   = 2'h2;
  localparam int SRC_LSB      = 0;
  localparam int BYPASS_BIT   = 16;
  localparam int EXTERNAL_BIT = 17;
  localparam int RUNNING_BIT  = 16;

  // Field widths and reset values.
  localparam int SETTLE_W = 16;
  localparam int CT_W     = 7;
  localparam logic [15:0] HF_SETTLE_RST   = 16'h0010;
  localparam logic [15:0] SLOW_SETTLE_RST = 16'h0020;
  localparam logic [6:0]  CT_INTERVAL_RST = 7'h10;
  localparam logic [17:0] SRC_SEL_RST     = 18'h00000;

  // Cycles that one RC calibration takes once the fast crystal runs.
  localparam int CAL_CYCLES = 16;

endpackage : ctc_pkg

// ==== hw/ctc_countdown.sv ====
// Loadable down counter that reports when its loaded count has run out.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module ctc_countdown #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic             abort,
  input  wire logic [WIDTH-1:0] value,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] count_reg;

  // A load of N gives done N+1 cycles later; abort drops the count silently.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (load) begin
        count_reg <= value;
        busy      <= 1'b1;
      end else if (busy) begin
        if (count_reg == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule : ctc_countdown

`default_nettype wire

// ==== tb/ctc_properties.sv ====
// Port checker of the clock task and event controller.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ctc_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rd_data,
  input wire logic        irq,
  input wire logic        fast_crystal_osc_en,
  input wire logic        slow_rc_osc_en,
  input wire logic        slow_crystal_osc_en,
  input wire logic        slow_clock_on_crystal,
  input wire logic        cal_ref_request
);
  wire tk = wr_stb && wr_data[0];
  wire se = slow_rc_osc_en || slow_crystal_osc_en;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_fast_start: assert property (tk && addr == 12'h000 |=> fast_crystal_osc_en)
    else $error("fast enable not set");
  a_fast_stop: assert property (tk && addr == 12'h004 |=> !fast_crystal_osc_en)
    else $error("fast enable not cleared");
  a_task_zero: assert property (rd_stb && addr[11:8] == 4'h0 |=> rd_data == 32'h0)
    else $error("task read not zero");
  a_fast_req: assert property (
    fast_crystal_osc_en && rd_stb && addr == 12'h408 |=> rd_data == 32'h1)
    else $error("fast request flag wrong");
  a_slow_req: assert property (
    se && rd_stb && addr == 12'h414 |=> rd_data == 32'h1)
    else $error("slow request flag wrong");
  a_slow_stop: assert property (tk && addr == 12'h00c |=>
    !(se || slow_clock_on_crystal))
    else $error("slow enables not cleared");
  a_on_crystal: assert property (slow_clock_on_crystal |-> slow_crystal_osc_en)
    else $error("switched without crystal");
  a_cal_request: assert property (tk && addr == 12'h010 |=> cal_ref_request)
    else $error("calibration request missing");
  a_irq_masked: assert property (wr_stb && addr == 12'h308 && wr_data[5:0] == 6'h3f
    ##1 !(wr_stb && addr == 12'h304) |=> !irq)
    else $error("interrupt while all masked");
  c_fast_on: cover property (fast_crystal_osc_en);
  c_crystal: cover property (slow_clock_on_crystal);
  c_irq: cover property (irq);
endmodule : ctc_properties
bind ctc_clock_ctrl ctc_properties i_props (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the clock task and event controller.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'h0;
  logic        rst     = 1'h1;
  logic [11:0] addr    = 12'h0;
  logic [31:0] wr_data = 32'h0;
  logic        wr_stb  = 1'h0;
  logic        rd_stb  = 1'h0;
  logic [31:0] rd_data;
  logic        irq, fce, sre, sce, soc, crq;
  logic [31:0] d;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  ctc_clock_ctrl #(.CAL_CYCLES(2)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .fast_crystal_osc_en(fce),
    .slow_rc_osc_en(sre), .slow_crystal_osc_en(sce), .slow_clock_on_crystal(soc),
    .cal_ref_request(crq));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= v;
    wr_stb  <= 1'h1;
    @(posedge clk_sys);
    wr_stb  <= 1'h0;
    #1;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge clk_sys);
    rd_stb <= 1'h0;
    #1;
    d = rd_data;
  endtask : rd
  task poll(input logic [11:0] a);
    d = 32'h0;
    for (int n = 0; n < 200 && d[0] !== 1'h1; n++) begin
      rd(a);
    end
  endtask : poll
  task t_reset;
    static logic [11:0] a [6] = '{12'h528, 12'h52c, 12'h538, 12'h518, 12'h000, 12'h7fc};
    static logic [31:0] e [6] = '{32'h10, 32'h20, 32'h10, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(a[i]);
      chk(d, e[i]);
    end
  endtask : t_reset
  task t_fast_cal;
    wr(12'h528, 32'h30);
    wr(12'h000, 32'h0);
    chk({31'h0, fce}, 32'h0);
    wr(12'h000, 32'h1);
    chk({31'h0, fce}, 32'h1);
    rd(12'h408);
    chk(d, 32'h1);
    repeat (40) @(posedge clk_sys);
    rd(12'h100);
    chk(d, 32'h0);
    poll(12'h100);
    chk(d, 32'h1);
    rd(12'h40c);
    chk(d, 32'h10001);
    wr(12'h100, 32'h0);
    rd(12'h100);
    chk(d, 32'h0);
    wr(12'h010, 32'h1);
    chk({31'h0, crq}, 32'h1);
    poll(12'h10c);
    chk({d[30:0], crq}, 32'h2);
    wr(12'h004, 32'h1);
    chk({31'h0, fce}, 32'h0);
  endtask : t_fast_cal
  task t_slow;
    wr(12'h518, 32'h1);
    wr(12'h008, 32'h1);
    chk({29'h0, sce, sre, soc}, 32'h6);
    rd(12'h41c);
    chk(d, 32'h1);
    rd(12'h414);
    chk(d, 32'h1);
    poll(12'h104);
    chk({29'h0, sce, sre, soc}, 32'h5);
    rd(12'h418);
    chk(d, 32'h10001);
    wr(12'h00c, 32'h1);
    wr(12'h518, 32'h0);
    wr(12'h008, 32'h1);
    chk({29'h0, sce, sre, soc}, 32'h2);
    rd(12'h418);
    chk(d, 32'h10000);
    rd(12'h41c);
    chk(d, 32'h0);
    wr(12'h00c, 32'h1);
    wr(12'h518, 32'h2);
    wr(12'h008, 32'h1);
    chk({29'h0, sce, sre, soc}, 32'h0);
    rd(12'h418);
    chk(d, 32'h10002);
    wr(12'h00c, 32'h1);
  endtask : t_slow
  task t_timer;
    wr(12'h308, 32'h3f);
    rd(12'h300);
    wr(12'h304, 32'h10);
    rd(12'h304);
    chk(d, 32'h10);
    wr(12'h538, 32'h8);
    @(posedge clk_sys);
    addr    <= 12'h014;
    wr_data <= 32'h1;
    wr_stb  <= 1'h1;
    @(posedge clk_sys);
    addr    <= 12'h018;
    @(posedge clk_sys);
    wr_stb  <= 1'h0;
    poll(12'h128);
    chk(d, 32'h1);
    @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, 32'h1);
    poll(12'h110);
    chk(d, 32'h1);
    rd(12'h300);
    chk({29'h0, d[5:3]}, 32'h3);
    @(posedge clk_sys);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr(12'h018, 32'h1);
    poll(12'h12c);
    chk(d, 32'h1);
    rd(12'h300);
    wr(12'h538, 32'h40);
    wr(12'h014, 32'h1);
    wr(12'h014, 32'h1);
    wr(12'h018, 32'h1);
    rd(12'h300);
    chk({26'h0, d[5:0]}, 32'h30);
    repeat (80) @(posedge clk_sys);
    rd(12'h300);
    chk(d, 32'h0);
  endtask : t_timer
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset();
    t_fast_cal();
    t_slow();
    t_timer();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
